// File: pkg/acsp_defs.svh
`ifndef ACSP_DEFS_SVH
`define ACSP_DEFS_SVH

// Command bytes
`define ACSP_CMD_CAL_OFFSET 8'h81
`define ACSP_CMD_CONVERT    8'h80
`define ACSP_CMD_RD_GAIN1   8'h0A
`define ACSP_CMD_WR_GAIN1   8'h02
`define ACSP_CMD_RD_CFG     8'h0B
`define ACSP_CMD_WR_CFG     8'h03

// Framing
`define ACSP_BYTE_ONES      8'hFF
`define ACSP_RESYNC_BYTES   4'hF
`define ACSP_BIT_LAST       3'h7
`define ACSP_WORD_MSB       5'h17
`define ACSP_TRAILER        4'hE

// Configuration register fields
`define ACSP_CFG_RC         14
`define ACSP_CFG_MC         15
`define ACSP_CFG_LP         16

// Reset values
`define ACSP_CFG_RST        24'h00_0000
`define ACSP_GAIN_RST       24'h80_0000
`define ACSP_XS_RST         8'hC0

`endif

// File: pkg/acsp_pkg.sv
package acsp_pkg;

  typedef enum logic [2:0]
  {
    st_cmd   = 3'h0,
    st_wdata = 3'h1,
    st_rdata = 3'h2,
    st_wait  = 3'h3,
    st_zero  = 3'h4
  } acsp_link_state_t;

  typedef enum logic [1:0]
  {
    c_idle  = 2'h0,
    c_run   = 2'h1,
    c_fetch = 2'h2
  } acsp_core_state_t;

endpackage

// File: verilog/acsp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; a bit changes once stages two and three agree
module acsp_sync #(
  parameter int unsigned   W    = 1,
  parameter logic [W-1:0]  INIT = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  if (W < 1)
  begin : g_bad
    $error("acsp_sync: width must be at least one");
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end
    else
    begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  for (genvar b = 0; b < W; b++)
  begin : g_bit
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        o_q[b] <= INIT[b];
      else if (s2[b] == s3[b])
        o_q[b] <= s3[b];
    end
  end
endmodule

`default_nettype wire

// File: verilog/acsp_offset_mem.sv
`timescale 1ns/1ps
`default_nettype none

// Per-channel offset store with registered read data
module acsp_offset_mem #(
  parameter int unsigned AW = 2,
  parameter int unsigned W  = 24
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);
  localparam int unsigned DEPTH = 1 << AW;

  logic [W-1:0] mem [DEPTH];

  if (AW < 1 || W < 1)
  begin : g_bad
    $error("acsp_offset_mem: unsupported size");
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else if (i_we)
      mem[i_waddr] <= i_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= '0;
    else if (i_re)
      o_rdata <= mem[i_raddr];
  end
endmodule

`default_nettype wire

// File: verilog/acsp_top.sv
// Notes on behaviour
// - Command 0x81 starts a self-offset calibration on the first setup.
// - Data out goes low when calibration ends; host polls for it.
// - Calibration writes the offset of the setup's physical channel.
// - Register write is command byte plus three data bytes, one access.
// - Command 0x0A reads the gain register of physical channel one.
// - After a read command, 24 bits are shifted out MSB first.
// - Single conversion only when multi-conversion and loop bits are zero.
// - Command 0x80 starts a conversion on the first setup.
// - Data out low at conversion end; host then sends eight zero clocks.
// - Result goes out as three bytes MSB first; 24-bit uses all bits.
// - 16-bit result third byte is 1110, channel, oscillation, overflow.
// - Fifteen all-ones bytes then a byte with LSB zero resync to command.
// - Command 0x0B reads configuration, 0x03 writes it.
`include "acsp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module acsp_top #(
  parameter int unsigned CHANNELS    = 4,
  parameter int unsigned RES_BITS    = 24,
  parameter int unsigned CONV_CYCLES = 64
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_sclk,
  input  wire logic                         i_cs_n,
  input  wire logic                         i_serial_in_line,
  input  wire logic [23:0]                  i_sample_data,
  input  wire logic [$clog2(CHANNELS)-1:0]  i_setup1_channel,
  input  wire logic                         i_oscillation_detect_flag,
  input  wire logic                         i_overflow_flag,
  output logic                              o_serial_out_line,
  output logic                              o_serial_out_oe,
  output logic                              o_busy,
  output logic                              o_multi_conversion_bit,
  output logic                              o_loop_bit,
  output logic                              o_read_convert_bit
);
  import acsp_pkg::*;

  localparam int unsigned CH_W     = $clog2(CHANNELS);
  localparam int          CONV_LAT = CONV_CYCLES + 1;

  if (!(RES_BITS == 16 || RES_BITS == 24) ||
      !(CHANNELS == 2 || CHANNELS == 4) ||
      CONV_CYCLES < 1 || CONV_CYCLES > 250)
  begin : g_bad
    $error("acsp_top: unsupported parameter values");
  end

  // Link side, clocked by the serial clock
  acsp_link_state_t state;
  logic             link_rst;
  logic [2:0]       byte_bit;
  logic [3:0]       ones;
  logic [23:0]      rx;
  logic [23:0]      next_rx;
  logic [23:0]      cfg;
  logic [23:0]      gain;
  logic [23:0]      tx_word;
  logic [4:0]       bit_idx;
  logic             wr_cfg;
  logic             wait_cal;
  logic             cal_tog;
  logic             conv_tog;
  logic             ack_tog;
  logic             out_bit;
  logic             done_s;
  logic             byte_end;
  logic             resync;
  logic             dec_valid;

  // Core side
  acsp_core_state_t cstate;
  logic             rst_req;
  logic [7:0]       xs;
  logic [15:0]      timer;
  logic             cal_q;
  logic             conv_q;
  logic             ack_q;
  logic             cal_evt;
  logic             conv_evt;
  logic             ack_evt;
  logic             op_cal;
  logic             sdo_low;
  logic             done_tog;
  logic [CH_W-1:0]  ch_q;
  logic             mem_we;
  logic             mem_re;
  logic [23:0]      mem_rdata;
  logic [23:0]      diff;
  logic [23:0]      conv_word;

  // Crossings into the link domain
  // The request also loads every stage, so the link never runs unreset
  acsp_sync #(.INIT(1'b1)) u_lrst (
    .i_clk (i_sclk),
    .i_rst (rst_req),
    .i_d   (rst_req),
    .o_q   (link_rst)
  );

  acsp_sync u_done (
    .i_clk (i_sclk),
    .i_rst (link_rst),
    .i_d   (done_tog),
    .o_q   (done_s)
  );

  always_comb
  begin
    next_rx   = {rx[22:0], i_serial_in_line};
    byte_end  = (byte_bit == `ACSP_BIT_LAST);
    resync    = byte_end && (ones == `ACSP_RESYNC_BYTES) && !next_rx[0];
    dec_valid = !i_cs_n && (state == st_cmd) && byte_end && !resync;
  end

  // Bit framing and all-ones run counter, rising edge only
  always_ff @(posedge i_sclk)
  begin
    if (link_rst)
    begin
      byte_bit <= 3'h0;
      ones     <= 4'h0;
      rx       <= 24'h00_0000;
    end
    else if (!i_cs_n)
    begin
      byte_bit <= byte_bit + 3'h1;
      rx       <= next_rx;
      if (byte_end)
      begin
        if (next_rx[7:0] != `ACSP_BYTE_ONES)
          ones <= 4'h0;
        else if (ones != `ACSP_RESYNC_BYTES)
          ones <= ones + 4'h1;
      end
    end
  end

  // Command state machine
  always_ff @(posedge i_sclk)
  begin
    if (link_rst)
    begin
      state    <= st_cmd;
      bit_idx  <= 5'h00;
      tx_word  <= 24'h00_0000;
      wr_cfg   <= 1'b0;
      wait_cal <= 1'b0;
      cal_tog  <= 1'b0;
      conv_tog <= 1'b0;
      ack_tog  <= 1'b0;
    end
    else if (!i_cs_n)
    begin
      unique case (state)
        st_cmd:
          if (dec_valid)
          begin
            case (next_rx[7:0])
              `ACSP_CMD_CAL_OFFSET:
              begin
                cal_tog  <= ~cal_tog;
                wait_cal <= 1'b1;
                state    <= st_wait;
              end
              `ACSP_CMD_CONVERT:
                if (!cfg[`ACSP_CFG_MC] && !cfg[`ACSP_CFG_LP])
                begin
                  conv_tog <= ~conv_tog;
                  wait_cal <= 1'b0;
                  state    <= st_wait;
                end
              `ACSP_CMD_RD_GAIN1:
              begin
                tx_word <= gain;
                bit_idx <= `ACSP_WORD_MSB;
                state   <= st_rdata;
              end
              `ACSP_CMD_RD_CFG:
              begin
                tx_word <= cfg;
                bit_idx <= `ACSP_WORD_MSB;
                state   <= st_rdata;
              end
              `ACSP_CMD_WR_CFG:
              begin
                wr_cfg  <= 1'b1;
                bit_idx <= `ACSP_WORD_MSB;
                state   <= st_wdata;
              end
              `ACSP_CMD_WR_GAIN1:
              begin
                wr_cfg  <= 1'b0;
                bit_idx <= `ACSP_WORD_MSB;
                state   <= st_wdata;
              end
              default:
                state <= st_cmd;
            endcase
          end
        st_wdata, st_rdata:
          if (bit_idx == 5'h00)
            state <= st_cmd;
          else
            bit_idx <= bit_idx - 5'h01;
        st_wait:
          if (done_s != ack_tog)
          begin
            ack_tog <= done_s;
            state   <= wait_cal ? st_cmd : st_zero;
          end
        st_zero:
          if (byte_end)
          begin
            tx_word <= conv_word;
            bit_idx <= `ACSP_WORD_MSB;
            state   <= st_rdata;
          end
        default:
          state <= st_cmd;
      endcase
      if (resync)
        state <= st_cmd;
    end
  end

  // Configuration and channel-one gain registers
  always_ff @(posedge i_sclk)
  begin
    if (link_rst)
    begin
      cfg  <= `ACSP_CFG_RST;
      gain <= `ACSP_GAIN_RST;
    end
    else if (!i_cs_n && state == st_wdata && bit_idx == 5'h00 && !resync)
    begin
      if (wr_cfg)
        cfg <= next_rx;
      else
        gain <= next_rx;
    end
  end

  // Output bit changes on the falling edge
  always_ff @(negedge i_sclk)
  begin
    if (link_rst)
      out_bit <= 1'b1;
    else if (!i_cs_n)
      out_bit <= (state == st_rdata) ? tx_word[bit_idx] : 1'b1;
  end

  // Crossings into the core domain
  acsp_sync #(.W(8), .INIT(`ACSP_XS_RST)) u_xs (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_cs_n, out_bit, cal_tog, conv_tog, ack_tog,
             cfg[`ACSP_CFG_MC], cfg[`ACSP_CFG_LP], cfg[`ACSP_CFG_RC]}),
    .o_q   (xs)
  );

  acsp_offset_mem #(.AW(CH_W)) u_mem (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_we    (mem_we),
    .i_waddr (ch_q),
    .i_wdata (i_sample_data),
    .i_re    (mem_re),
    .i_raddr (ch_q),
    .o_rdata (mem_rdata)
  );

  always_comb
  begin
    cal_evt  = xs[5] ^ cal_q;
    conv_evt = xs[4] ^ conv_q;
    ack_evt  = xs[3] ^ ack_q;
    mem_re   = (cstate == c_run) && (timer == 16'h0000);
    mem_we   = (cstate == c_fetch) && op_cal;
    diff     = i_sample_data - mem_rdata;
  end

  always_ff @(posedge i_clk)
  begin
    rst_req <= i_rst;
  end

  // Calibration and conversion sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cstate    <= c_idle;
      timer     <= 16'h0000;
      cal_q     <= 1'b0;
      conv_q    <= 1'b0;
      ack_q     <= 1'b0;
      op_cal    <= 1'b0;
      ch_q      <= '0;
      done_tog  <= 1'b0;
      conv_word <= 24'h00_0000;
    end
    else
    begin
      cal_q  <= xs[5];
      conv_q <= xs[4];
      ack_q  <= xs[3];
      unique case (cstate)
        c_idle:
          if (cal_evt || conv_evt)
          begin
            op_cal <= cal_evt;
            ch_q   <= i_setup1_channel;
            timer  <= 16'(CONV_CYCLES - 1);
            cstate <= c_run;
          end
        c_run:
          if (timer == 16'h0000)
            cstate <= c_fetch;
          else
            timer <= timer - 16'h0001;
        c_fetch:
        begin
          if (!op_cal)
          begin
            if (RES_BITS == 24)
              conv_word <= diff;
            else
              conv_word <= {diff[23:8], `ACSP_TRAILER, 2'(ch_q),
                            i_oscillation_detect_flag,
                            i_overflow_flag};
          end
          done_tog <= ~done_tog;
          cstate   <= c_idle;
        end
        default:
          cstate <= c_idle;
      endcase
    end
  end

  // Completion level on data out; a new completion wins over the ack
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      sdo_low <= 1'b0;
    else if (cstate == c_fetch)
      sdo_low <= 1'b1;
    else if (ack_evt)
      sdo_low <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_serial_out_line      <= 1'b1;
      o_serial_out_oe        <= 1'b0;
      o_busy                 <= 1'b0;
      o_multi_conversion_bit <= 1'b0;
      o_loop_bit             <= 1'b0;
      o_read_convert_bit     <= 1'b0;
    end
    else
    begin
      o_serial_out_line      <= sdo_low ? 1'b0 : xs[6];
      o_serial_out_oe        <= !xs[7];
      o_busy                 <= (cstate != c_idle);
      o_multi_conversion_bit <= xs[2];
      o_loop_bit             <= xs[1];
      o_read_convert_bit     <= xs[0];
    end
  end

  sdo_fall_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (cstate == c_fetch) |-> ##2 !o_serial_out_line)
    else $error("data out did not fall after completion");

  conv_time_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (cstate == c_idle && (cal_evt || conv_evt)) |-> ##CONV_LAT
    (cstate == c_fetch))
    else $error("sequencer finished at the wrong time");

  cal_target_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (cstate == c_idle && cal_evt) |-> ##CONV_LAT
    (mem_we && ch_q == $past(i_setup1_channel, CONV_LAT)))
    else $error("calibration wrote the wrong channel");

  short_trailer_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (cstate == c_fetch && !op_cal && RES_BITS == 16) |=>
    (conv_word[7:4] == `ACSP_TRAILER && conv_word[1] == $past(
     i_oscillation_detect_flag)))
    else $error("short result trailer wrong");

  cal_cmd_a: assert property (
    @(posedge i_sclk) disable iff (link_rst)
    (dec_valid && next_rx[7:0] == `ACSP_CMD_CAL_OFFSET) |=>
    (state == st_wait && cal_tog != $past(cal_tog)))
    else $error("calibration command not taken");

  single_conv_a: assert property (
    @(posedge i_sclk) disable iff (link_rst)
    (dec_valid && next_rx[7:0] == `ACSP_CMD_CONVERT &&
     (cfg[`ACSP_CFG_MC] || cfg[`ACSP_CFG_LP])) |=>
    (state == st_cmd && $stable(conv_tog)))
    else $error("conversion started with repeat bits set");

  gain_read_a: assert property (
    @(posedge i_sclk) disable iff (link_rst)
    (dec_valid && next_rx[7:0] == `ACSP_CMD_RD_GAIN1) |=>
    (state == st_rdata && tx_word == $past(gain) &&
     bit_idx == `ACSP_WORD_MSB))
    else $error("gain read not loaded");

  cfg_read_a: assert property (
    @(posedge i_sclk) disable iff (link_rst)
    (dec_valid && next_rx[7:0] == `ACSP_CMD_RD_CFG) |=>
    (state == st_rdata && tx_word == $past(cfg)))
    else $error("configuration read not loaded");

  resync_cmd_a: assert property (
    @(posedge i_sclk) disable iff (link_rst)
    (resync && !i_cs_n) |=> (state == st_cmd))
    else $error("resync did not return to command state");

  read_hold_a: assert property (
    @(posedge i_sclk) disable iff (link_rst)
    $rose(state == st_rdata) |-> (state == st_rdata)[*8])
    else $error("read data state left early");

  cfg_write_a: assert property (
    @(posedge i_sclk) disable iff (link_rst)
    (state == st_wdata && bit_idx == 5'h00 && wr_cfg && !i_cs_n &&
     !resync) |=> (cfg == $past(next_rx) && state == st_cmd))
    else $error("configuration write lost");

  cs_idle_a: assert property (
    @(posedge i_sclk) disable iff (link_rst)
    i_cs_n |=> ($stable(state) && $stable(cfg)))
    else $error("port moved while deselected");

  cal_done_c: cover property (
    @(posedge i_clk) disable iff (i_rst)
    (cstate == c_fetch && op_cal));

  conv_read_c: cover property (
    @(posedge i_sclk) disable iff (link_rst)
    (state == st_zero) ##[1:8] (state == st_rdata));

  resync_c: cover property (
    @(posedge i_sclk) disable iff (link_rst)
    (resync && !i_cs_n));

  gain_write_c: cover property (
    @(posedge i_sclk) disable iff (link_rst)
    (state == st_wdata && bit_idx == 5'h00 && !wr_cfg && !i_cs_n));
endmodule

`default_nettype wire

// File: verification/acsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the serial port: clock stands low outside transfers
module acsp_host_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_serial_in_line,
  input  wire logic i_serial_out_line,
  input  wire logic i_serial_out_oe
);
  localparam time HALF = 24;

  wire logic seen;

  // A released data-out line shows the inverse of its last level
  assign seen = i_serial_out_oe ? i_serial_out_line : ~i_serial_out_line;

  initial
  begin
    o_sclk           = 1'b0;
    o_cs_n           = 1'b1;
    o_serial_in_line = 1'b0;
  end

  // Edges with select high, used while the link is held in reset and to check that a deselected port ignores them
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
  endtask

  task automatic select(input logic en);
    #HALF;
    o_cs_n = ~en;
    if (!en) o_serial_in_line = ~o_serial_in_line;
    #HALF;
  endtask

  // One byte each way, MSB first; 48 ns bit period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--)
    begin
      o_serial_in_line = tx[b];
      #HALF;
      rx[b] = seen;
      o_sclk = 1'b1;
      #HALF;
      o_sclk = 1'b0;
    end
  endtask

  task automatic send_word(input logic [7:0] cmd, input logic [23:0] w);
    logic [7:0] r;
    xfer(cmd, r);
    for (int k = 2; k >= 0; k--)
      xfer(w[8*k +: 8], r);
  endtask

  task automatic read24(output logic [23:0] w);
    logic [7:0] r;
    for (int k = 2; k >= 0; k--)
    begin
      xfer(8'h00, r);
      w[8*k +: 8] = r;
    end
  endtask

  task automatic poll_low(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 500 && !ok; n++)
    begin
      #4;
      ok = (seen === 1'b0);
    end
  endtask

  task automatic resync();
    logic [7:0] r;
    repeat (15) xfer(8'hFF, r);
    xfer(8'hFE, r);
  endtask
endmodule

`default_nettype wire

// File: verification/acsp_top_tb.sv
`include "acsp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module acsp_top_tb;
  import acsp_pkg::*;
  localparam int unsigned CONV = 8;

  logic        i_clk;
  logic        i_rst;
  wire logic   sclk;
  wire logic   cs_n;
  wire logic   serial_in_line;
  logic [23:0] sample;
  logic [1:0]  chan;
  logic        osc;
  logic        ovf;
  wire logic   serial_out_line;
  wire logic   sdo_oe;
  wire logic   sdo16;
  logic [23:0] sh16;
  int          busy_cyc;
  wire logic   busy;
  wire logic   mc;
  wire logic   lp;
  wire logic   rc;
  logic [31:0] rng;
  int          errors;
  int          n_tests;

  acsp_top #(.CONV_CYCLES(CONV)) acsp_top_i (
    .i_clk                     (i_clk),
    .i_rst                     (i_rst),
    .i_sclk                    (sclk),
    .i_cs_n                    (cs_n),
    .i_serial_in_line          (serial_in_line),
    .i_sample_data             (sample),
    .i_setup1_channel          (chan),
    .i_oscillation_detect_flag (osc),
    .i_overflow_flag           (ovf),
    .o_serial_out_line         (serial_out_line),
    .o_serial_out_oe           (sdo_oe),
    .o_busy                    (busy),
    .o_multi_conversion_bit    (mc),
    .o_loop_bit                (lp),
    .o_read_convert_bit        (rc)
  );

  acsp_host_model acsp_host_model_i (
    .o_sclk            (sclk),
    .o_cs_n            (cs_n),
    .o_serial_in_line  (serial_in_line),
    .i_serial_out_line (serial_out_line),
    .i_serial_out_oe   (sdo_oe)
  );

  // Short-result variant shares the link and core inputs
  if (1'b1)
  begin : g_short
    acsp_top #(.RES_BITS(16), .CONV_CYCLES(CONV)) acsp_top_i (
      .i_clk                     (i_clk),
      .i_rst                     (i_rst),
      .i_sclk                    (sclk),
      .i_cs_n                    (cs_n),
      .i_serial_in_line          (serial_in_line),
      .i_sample_data             (sample),
      .i_setup1_channel          (chan),
      .i_oscillation_detect_flag (osc),
      .i_overflow_flag           (ovf),
      .o_serial_out_line         (sdo16),
      .o_serial_out_oe           (),
      .o_busy                    (),
      .o_multi_conversion_bit    (),
      .o_loop_bit                (),
      .o_read_convert_bit        ()
    );
  end

  // Collects the short variant's data out at each selected rising edge
  always @(posedge sclk)
  begin
    if (!cs_n)
      sh16 <= {sh16[22:0], sdo16};
  end

  always @(posedge i_clk)
  begin
    if (busy === 1'b1)
      busy_cyc++;
  end

  always #2 i_clk = ~i_clk;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [23:0] conv_exp(input logic [23:0] s,
                                           input logic [23:0] off);
    return s - off;
  endfunction

  // Short result: top sixteen difference bits, fixed nibble, channel, flags
  function automatic logic [23:0] conv16_exp(input logic [23:0] s,
                                             input logic [23:0] off,
                                             input logic [1:0]  ch,
                                             input logic        o,
                                             input logic        f);
    logic [23:0] d;
    d = s - off;
    return {d[23:8], `ACSP_TRAILER, ch, o, f};
  endfunction

  // Clears read-convert, multi-conversion and loop, keeps the rest
  function automatic logic [23:0] single_cfg(input logic [23:0] c);
    return c & ~24'h01_C000;
  endfunction

  task automatic draw(output logic [23:0] v);
    rng = next_rand(rng);
    v = rng[23:0];
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic set_core(input logic [23:0] s, input logic [1:0] ch);
    @(posedge i_clk);
    sample <= s;
    chan <= ch;
    osc <= rng[0];
    ovf <= rng[1];
    // Keeps the link edges off the core clock edges
    #1.3;
  endtask

  task automatic do_convert(input logic [23:0] s, input logic [1:0] ch,
                            input logic [23:0] off);
    logic [7:0]  r;
    logic [23:0] w;
    logic        ok;
    set_core(s, ch);
    acsp_host_model_i.xfer(`ACSP_CMD_CONVERT, r);
    acsp_host_model_i.poll_low(ok);
    check({23'h0, ok}, 24'h00_0001, "conversion done");
    acsp_host_model_i.xfer(8'h00, r);
    acsp_host_model_i.read24(w);
    check(w, conv_exp(s, off), "result");
    check(sh16, conv16_exp(s, off, ch, osc, ovf), "short");
  endtask

  initial
  begin
    #300us;
    errors++;
    complete_run();
  end

  initial
  begin
    logic [7:0]  r;
    logic [23:0] w;
    logic [23:0] a;
    logic [23:0] g;
    logic [23:0] cfg;
    logic [1:0]  ch;
    logic        ok;
    int          b0;
    i_clk   = 1'b0;
    i_rst   = 1'b1;
    sample  = 24'h00_0000;
    chan    = 2'h0;
    osc     = 1'b0;
    ovf     = 1'b0;
    rng     = 32'h0001_064D;
    errors  = 0;
    n_tests = 0;
    acsp_host_model_i.idle_clocks(6);
    @(posedge i_clk);
    #1;
    check({21'h0, serial_out_line, sdo_oe, busy}, 24'h00_0004,
          "reset outputs");
    @(posedge i_clk);
    i_rst <= 1'b0;
    acsp_host_model_i.idle_clocks(4);
    #1.3;
    acsp_host_model_i.select(1'b1);
    acsp_host_model_i.resync();
    acsp_host_model_i.xfer(`ACSP_CMD_RD_GAIN1, r);
    acsp_host_model_i.read24(w);
    check(w, `ACSP_GAIN_RST, "gain after reset");
    check({23'h0, sdo_oe}, 24'h00_0001, "drive enable");
    for (int i = 0; i < 3; i++)
    begin
      draw(g);
      if (i < 2) g = i ? 24'h00_0000 : 24'hFF_FFFF;
      acsp_host_model_i.send_word(`ACSP_CMD_WR_GAIN1, g);
      acsp_host_model_i.xfer(`ACSP_CMD_RD_GAIN1, r);
      acsp_host_model_i.read24(w);
      check(w, g, "gain readback");
    end
    draw(cfg);
    cfg[15] = 1'b1;
    acsp_host_model_i.send_word(`ACSP_CMD_WR_CFG, cfg);
    acsp_host_model_i.xfer(`ACSP_CMD_RD_CFG, r);
    acsp_host_model_i.read24(w);
    check(w, cfg, "config readback");
    for (int n = 0; n < 50 && mc !== 1'b1; n++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
    check({21'h0, mc, lp, rc}, {21'h0, cfg[15], cfg[16], cfg[14]},
          "config bits");
    b0 = busy_cyc;
    acsp_host_model_i.xfer(`ACSP_CMD_CONVERT, r);
    repeat (CONV + 40) @(posedge i_clk);
    #1;
    check({22'h0, busy, serial_out_line}, 24'h00_0001, "refused convert");
    check(24'(busy_cyc - b0), 24'h00_0000, "refused run");
    acsp_host_model_i.send_word(`ACSP_CMD_WR_CFG, single_cfg(cfg));
    draw(a);
    ch = a[1:0];
    set_core(a, ch);
    b0 = busy_cyc;
    acsp_host_model_i.xfer(`ACSP_CMD_CAL_OFFSET, r);
    acsp_host_model_i.poll_low(ok);
    check({23'h0, ok}, 24'h00_0001, "calibration done");
    check(24'(busy_cyc - b0), 24'(CONV + 1), "busy span");
    draw(w);
    do_convert(w, ch, a);
    draw(w);
    do_convert(w, ch ^ 2'h1, 24'h00_0000);
    acsp_host_model_i.select(1'b0);
    repeat (20) @(posedge i_clk);
    check({23'h0, sdo_oe}, 24'h00_0000, "released");
    acsp_host_model_i.idle_clocks(16);
    acsp_host_model_i.select(1'b1);
    acsp_host_model_i.xfer(`ACSP_CMD_RD_GAIN1, r);
    acsp_host_model_i.read24(w);
    check(w, g, "deselected edges ignored");
    acsp_host_model_i.select(1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
